// File: design/gpio_port_map.svh
// register map, field layout, reset values and codes of the gpio port
`ifndef GPIO_PORT_MAP_SVH
`define GPIO_PORT_MAP_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define PIN_LEVEL_DATA_IDX 16'hf260
`define PIN_DIRECTION_IDX 16'hf261
`define DRIVE_CONFIG_LOW_IDX 16'hf262
`define DRIVE_CONFIG_HIGH_IDX 16'hf263
`define FUNCTION_SELECT_LOW_IDX 16'hf264
`define FUNCTION_SELECT_HIGH_IDX 16'hf265

// ----------------------------------------------------------------------
// bus layout
// ----------------------------------------------------------------------
`define WB_ADR_W 18
`define IDX_MSB 17
`define IDX_LSB 2
`define LANE_LO_MSB 7
`define LANE_HI_LSB 8
`define LANE_HI_MSB 15
`define SEL_LO 0
`define SEL_HI 1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PORT_BYTE_RST 8'h00
`define BUS_WORD_RST 32'h0000_0000

// ----------------------------------------------------------------------
// drive / termination codes, {high bit, low bit}
// ----------------------------------------------------------------------
`define DRV_HIZ 2'h0
`define DRV_P_OPEN 2'h1
`define DRV_N_OPEN 2'h2
`define DRV_CMOS 2'h3
`define TERM_PULL_DOWN 2'h1
`define TERM_PULL_UP 2'h2

// ----------------------------------------------------------------------
// pins that carry each alternate function
// ----------------------------------------------------------------------
`define SECOND_FUNC_PINS 8'h63
`define THIRD_FUNC_PINS 8'h73
`define FOURTH_FUNC_PINS 8'h03
`define EVENT45_PIN 2
`define EVENT67_PIN 3

`endif

// File: design/gpio_port_pkg.sv
// types shared by the gpio port and its pin cell
package gpio_port_pkg;

  // ----------------------------------------------------------------------
  // function selected for one pin
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FUNC_GPIO,
    FUNC_SECOND,
    FUNC_THIRD,
    FUNC_FOURTH
  } func_sel_t;

  // ----------------------------------------------------------------------
  // one classic wishbone request as seen by the slave
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [15:0] index;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  // ----------------------------------------------------------------------
  // pad drive of one pin
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic pad;
    logic oe;
    logic pull_up;
    logic pull_down;
  } pin_drive_t;

endpackage : gpio_port_pkg

// File: design/gpio_pin_cell.sv
// one pad cell: input synchroniser and registered drive decode
`timescale 1ns/1ns
`default_nettype none
`include "gpio_port_map.svh"
module gpio_pin_cell
  import gpio_port_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pad side
  input wire logic pad_i,
  output var pin_drive_t drive_o,
  // control from the register file
  input wire logic is_input_i,
  input wire logic [1:0] drive_code_i,
  input wire logic value_i,
  // synchronised pad level
  output logic level_o
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic meta;
  logic next_meta;
  logic next_level;
  pin_drive_t next_drive;

  // two flops before anything looks at the pad level
  always_comb begin
    next_meta = pad_i;
    next_level = meta;
  end

  // decode drive and termination; 1 on value_i is a high level
  always_comb begin
    next_drive = '0;
    if (!is_input_i) begin
      case (drive_code_i)
        `DRV_P_OPEN: begin
          next_drive.pad = 1'b1; // only the high side can source
          next_drive.oe = value_i;
        end
        `DRV_N_OPEN: begin
          next_drive.pad = 1'b0; // only the low side can sink
          next_drive.oe = !value_i;
        end
        `DRV_CMOS: begin
          next_drive.pad = value_i;
          next_drive.oe = 1'b1;
        end
        default: begin
          next_drive.oe = 1'b0; // hi-z output holds the pad free
        end
      endcase
    end else begin
      case (drive_code_i)
        `TERM_PULL_DOWN: next_drive.pull_down = 1'b1;
        `TERM_PULL_UP: next_drive.pull_up = 1'b1;
        default: next_drive.pull_up = 1'b0;
      endcase
    end
  end

  // registering the drive keeps the pads free of decode glitches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      level_o <= 1'b0;
      drive_o <= '0;
    end else begin
      meta <= next_meta;
      level_o <= next_level;
      drive_o <= next_drive;
    end
  end

endmodule : gpio_pin_cell
`default_nettype wire

// File: design/gpio_port.sv
// eight-pin gpio port with a classic wishbone register slave
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_port_map.svh"
module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int PIN_COUNT = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [`WB_ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // pads
  input wire logic [PIN_COUNT-1:0] pad_i,
  output logic [PIN_COUNT-1:0] pad_o,
  output logic [PIN_COUNT-1:0] pad_oe_o,
  output logic [PIN_COUNT-1:0] pull_up_o,
  output logic [PIN_COUNT-1:0] pull_down_o,
  // alternate function sources, same clock
  input wire logic [PIN_COUNT-1:0] alt_second_i,
  input wire logic [PIN_COUNT-1:0] alt_third_i,
  input wire logic [PIN_COUNT-1:0] alt_fourth_i,
  // synchronised pad levels for peripherals
  output logic [PIN_COUNT-1:0] pin_level_o,
  output logic pulse_ch45_event_input_o,
  output logic pulse_ch67_event_input_o
);

  // ----------------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------------
  // every register is one byte wide, so the port is fixed at eight pins
  if (PIN_COUNT != 8) begin : g_bad_pin_count
    $error("gpio_port supports exactly eight pins");
  end

  // ----------------------------------------------------------------------
  // request view of the bus
  // ----------------------------------------------------------------------
  wb_req_t req;
  logic take;

  // flatten the bus pins into one request
  assign req.cyc = cyc_i;
  assign req.stb = stb_i;
  assign req.we = we_i;
  assign req.index = adr_i[`IDX_MSB:`IDX_LSB];
  assign req.sel = sel_i;
  assign req.dat = dat_i;

  // a request is taken once, in the cycle before ack rises
  assign take = req.cyc && req.stb && !ack_o;

  // ----------------------------------------------------------------------
  // register hits
  // ----------------------------------------------------------------------
  logic hit_data;
  logic hit_dir;
  logic hit_drv_lo;
  logic hit_drv_hi;
  logic hit_fsel_lo;
  logic hit_fsel_hi;
  logic take_rd;

  // one compare per register, shared by the write and the read path so
  // the two can never disagree about which index names which register
  assign hit_data = req.index == `PIN_LEVEL_DATA_IDX;
  assign hit_dir = req.index == `PIN_DIRECTION_IDX;
  assign hit_drv_lo = req.index == `DRIVE_CONFIG_LOW_IDX;
  assign hit_drv_hi = req.index == `DRIVE_CONFIG_HIGH_IDX;
  assign hit_fsel_lo = req.index == `FUNCTION_SELECT_LOW_IDX;
  assign hit_fsel_hi = req.index == `FUNCTION_SELECT_HIGH_IDX;
  assign take_rd = take && !req.we;

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  logic [7:0] pin_level_data;
  logic [7:0] pin_direction;
  logic [7:0] drive_config_low;
  logic [7:0] drive_config_high;
  logic [7:0] function_select_low;
  logic [7:0] function_select_high;
  logic [7:0] next_pin_level_data;
  logic [7:0] next_pin_direction;
  logic [7:0] next_drive_config_low;
  logic [7:0] next_drive_config_high;
  logic [7:0] next_function_select_low;
  logic [7:0] next_function_select_high;
  logic wr_lo;
  logic wr_hi;
  logic [7:0] lane_lo;
  logic [7:0] lane_hi;

  // a write lane counts only while its byte enable is set
  assign wr_lo = take && req.we && req.sel[`SEL_LO];
  assign wr_hi = take && req.we && req.sel[`SEL_HI];
  assign lane_lo = req.dat[`LANE_LO_MSB:0];
  assign lane_hi = req.dat[`LANE_HI_MSB:`LANE_HI_LSB];

  // byte writes through lane 0; the low index of each pair also takes
  // lane 1 into the upper register, which gives the 16-bit word access
  always_comb begin
    next_pin_level_data = pin_level_data;
    next_pin_direction = pin_direction;
    next_drive_config_low = drive_config_low;
    next_drive_config_high = drive_config_high;
    next_function_select_low = function_select_low;
    next_function_select_high = function_select_high;
    // unmapped indices match no hit, so their writes fall away
    // lane 1 reaches an upper register only at the low index of its pair
    if (wr_lo && hit_data) begin
      next_pin_level_data = lane_lo;
    end
    if (wr_lo && hit_dir) begin
      next_pin_direction = lane_lo;
    end
    if (wr_lo && hit_drv_lo) begin
      next_drive_config_low = lane_lo;
    end
    if (wr_hi && hit_drv_lo) begin
      next_drive_config_high = lane_hi;
    end
    if (wr_lo && hit_drv_hi) begin
      next_drive_config_high = lane_lo;
    end
    if (wr_lo && hit_fsel_lo) begin
      next_function_select_low = lane_lo;
    end
    if (wr_hi && hit_fsel_lo) begin
      next_function_select_high = lane_hi;
    end
    if (wr_lo && hit_fsel_hi) begin
      next_function_select_high = lane_lo;
    end
  end

  // all registers clear on reset, so every pin starts as hi-z output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_level_data <= `PORT_BYTE_RST;
      pin_direction <= `PORT_BYTE_RST;
      drive_config_low <= `PORT_BYTE_RST;
      drive_config_high <= `PORT_BYTE_RST;
      function_select_low <= `PORT_BYTE_RST;
      function_select_high <= `PORT_BYTE_RST;
    end else begin
      pin_level_data <= next_pin_level_data;
      pin_direction <= next_pin_direction;
      drive_config_low <= next_drive_config_low;
      drive_config_high <= next_drive_config_high;
      function_select_low <= next_function_select_low;
      function_select_high <= next_function_select_high;
    end
  end

  // ----------------------------------------------------------------------
  // per-pin output value and function routing
  // ----------------------------------------------------------------------
  logic [7:0] pin_value;
  logic [7:0] sync_level;
  logic [7:0] read_level;
  func_sel_t func [8];

  // ----------------------------------------------------------------------
  // alternate function sources
  // ----------------------------------------------------------------------
  localparam logic [7:0] SECOND_PINS = `SECOND_FUNC_PINS;
  localparam logic [7:0] THIRD_PINS = `THIRD_FUNC_PINS;
  localparam logic [7:0] FOURTH_PINS = `FOURTH_FUNC_PINS;
  logic [7:0] second_value;
  logic [7:0] third_value;
  logic [7:0] fourth_value;

  // a function that the pin lacks leaves the value low, so n-drain and
  // cmos settings hold the pad low and p-drain leaves it floating
  assign second_value = alt_second_i & SECOND_PINS;
  assign third_value = alt_third_i & THIRD_PINS;
  assign fourth_value = alt_fourth_i & FOURTH_PINS;

  // each pin picks its source from its own two function-select bits
  always_comb begin
    pin_value = '0;
    for (int n = 0; n < 8; n++) begin
      func[n] = func_sel_t'({function_select_high[n],
                             function_select_low[n]});
      case (func[n])
        FUNC_GPIO: pin_value[n] = pin_level_data[n];
        FUNC_SECOND: pin_value[n] = second_value[n];
        FUNC_THIRD: pin_value[n] = third_value[n];
        FUNC_FOURTH: pin_value[n] = fourth_value[n];
        default: pin_value[n] = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // pad cells
  // ----------------------------------------------------------------------
  pin_drive_t drive [8];

  for (genvar n = 0; n < 8; n++) begin : g_pin
    gpio_pin_cell u_cell (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pad_i(pad_i[n]),
      .drive_o(drive[n]),
      .is_input_i(pin_direction[n]),
      .drive_code_i({drive_config_high[n], drive_config_low[n]}),
      .value_i(pin_value[n]),
      .level_o(sync_level[n])
    );
    // unpack the registered drive onto the pad ports
    assign pad_o[n] = drive[n].pad;
    assign pad_oe_o[n] = drive[n].oe;
    assign pull_up_o[n] = drive[n].pull_up;
    assign pull_down_o[n] = drive[n].pull_down;
  end

  // peripherals see the synchronised level of every pin; a data read returns it for input pins only
  assign pin_level_o = sync_level;
  assign pulse_ch45_event_input_o = sync_level[`EVENT45_PIN];
  assign pulse_ch67_event_input_o = sync_level[`EVENT67_PIN];

  // ----------------------------------------------------------------------
  // read-back levels
  // ----------------------------------------------------------------------
  // input pins read the synchronised pad, output pins the stored bit
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      read_level[n] = pin_direction[n] ? sync_level[n]
                                       : pin_level_data[n];
    end
  end

  // ----------------------------------------------------------------------
  // read data and acknowledge
  // ----------------------------------------------------------------------
  logic [31:0] next_dat;
  logic next_ack;

  logic [7:0] rd_lane_lo;
  logic [7:0] rd_lane_hi;

  // read mux by byte lane; the high register of each pair also shows in
  // lane 1 at its low index so that a word read returns both bytes
  always_comb begin
    rd_lane_lo = 8'h00;
    rd_lane_hi = 8'h00;
    if (hit_data) begin
      rd_lane_lo = read_level;
    end
    if (hit_dir) begin
      rd_lane_lo = pin_direction;
    end
    if (hit_drv_lo) begin
      rd_lane_lo = drive_config_low;
      rd_lane_hi = drive_config_high;
    end
    if (hit_drv_hi) begin
      rd_lane_lo = drive_config_high;
    end
    if (hit_fsel_lo) begin
      rd_lane_lo = function_select_low;
      rd_lane_hi = function_select_high;
    end
    if (hit_fsel_hi) begin
      rd_lane_lo = function_select_high;
    end
  end

  // unmapped addresses still ack and read zero, so a stray access never
  // hangs the bus; dat_o is zero outside the ack cycle of a read
  always_comb begin
    next_dat = `BUS_WORD_RST;
    next_ack = take;
    if (take_rd) begin
      next_dat = {16'h0000, rd_lane_hi, rd_lane_lo};
    end
  end

  // one wait state: ack comes the edge after the request is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= `BUS_WORD_RST;
      ack_o <= 1'b0;
    end else begin
      dat_o <= next_dat;
      ack_o <= next_ack;
    end
  end

endmodule : gpio_port
`default_nettype wire

// File: verification/gpio_port_chk.sv
// assertions on the gpio port's bus answer and pad pins
`timescale 1ns/1ns
`default_nettype none
`include "gpio_port_map.svh"
module gpio_port_chk #(
  parameter int PIN_COUNT = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [`WB_ADR_W-1:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // pads
  input wire logic [PIN_COUNT-1:0] pad_i,
  input wire logic [PIN_COUNT-1:0] pad_oe_o,
  input wire logic [PIN_COUNT-1:0] pull_up_o,
  input wire logic [PIN_COUNT-1:0] pull_down_o,
  input wire logic [PIN_COUNT-1:0] pin_level_o,
  input wire logic pulse_ch45_event_input_o,
  input wire logic pulse_ch67_event_input_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ------
  // bus answer
  // ------
  property p_ack_next;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack");
  property p_ack_one;
    ack_o |=> !ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held");
  property p_dat_quiet;
    !ack_o |-> dat_o == 32'h0000_0000;
  endproperty
  a_dat_quiet: assert property (p_dat_quiet) else $error("dat busy");
  property p_upper_zero;
    ack_o |-> dat_o[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper");
  // unmapped places answer with zero so software never sees stale data
  property p_unmapped;
    cyc_i && stb_i && !ack_o &&
      (adr_i[`IDX_MSB:`IDX_LSB] > `FUNCTION_SELECT_HIGH_IDX)
      |=> dat_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped");

  // ------
  // pads
  // ------
  property p_reset_hiz;
    $past(rst_i) |-> (pad_oe_o | pull_up_o | pull_down_o) == '0;
  endproperty
  a_reset_hiz: assert property (p_reset_hiz) else $error("hiz");
  property p_pull_excl;
    (pull_up_o & pull_down_o) == '0;
  endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("pulls");
  property p_pull_no_drive;
    ((pull_up_o | pull_down_o) & pad_oe_o) == '0;
  endproperty
  a_pull_no_drive: assert property (p_pull_no_drive) else $error("pd");
  // two synchroniser flops between pad and level
  property p_sync;
    !$past(rst_i) && !$past(rst_i, 2) |-> pin_level_o == $past(pad_i, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("sync");
  property p_event;
    {pulse_ch67_event_input_o, pulse_ch45_event_input_o} ==
      {pin_level_o[`EVENT67_PIN], pin_level_o[`EVENT45_PIN]};
  endproperty
  a_event: assert property (p_event) else $error("event");
endmodule : gpio_port_chk

bind gpio_port gpio_port_chk #(.PIN_COUNT(PIN_COUNT)) chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .pad_i(pad_i),
  .pad_oe_o(pad_oe_o), .pull_up_o(pull_up_o),
  .pull_down_o(pull_down_o), .pin_level_o(pin_level_o),
  .pulse_ch45_event_input_o(pulse_ch45_event_input_o),
  .pulse_ch67_event_input_o(pulse_ch67_event_input_o)
);
`default_nettype wire

// File: verification/gpio_board.sv
// board-side model of the eight pins: sources, pulls and floating nets
`timescale 1ns/1ns
`default_nettype none
module gpio_board (
  // clock
  input wire logic clk_i,
  // pad drive from the port
  input wire logic [7:0] drv_i,
  input wire logic [7:0] drv_en_i,
  input wire logic [7:0] pu_i,
  input wire logic [7:0] pd_i,
  // external source set by the bench
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  // level seen at the pads
  output logic [7:0] level_o
);
  logic [7:0] last = 8'h00;
  // remember the level so a floating pin can toggle
  always_ff @(posedge clk_i) begin
    last <= level_o;
  end
  // port drive wins, then the board source, then pulls; a floating net
  // toggles so that no test can pass on a settled unknown
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      if (drv_en_i[n]) begin
        level_o[n] = drv_i[n];
      end else if (ext_en_i[n]) begin
        level_o[n] = ext_val_i[n];
      end else if (pu_i[n] | pd_i[n]) begin
        level_o[n] = pu_i[n];
      end else begin
        level_o[n] = ~last[n];
      end
    end
  end
endmodule : gpio_board
`default_nettype wire

// File: verification/gpio_port_test.sv
// self-checking bench for the gpio port
`timescale 1ns/1ns
`default_nettype none
`include "gpio_port_map.svh"
module gpio_port_test import gpio_port_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [17:0] adr = 18'h0_0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, rd_q;
  logic [7:0] pad_i, pad_o, pad_oe, pu, pd, dv, mask;
  logic [7:0] lvl;
  logic ev45, ev67;
  logic [7:0] alt2 = 8'h00, alt3 = 8'h00, alt4 = 8'h00;
  logic [7:0] ext_en = 8'h00, ext_val = 8'h00;
  int num_errors = 0;
  int checks_done = 0;

  gpio_port #(.PIN_COUNT(8)) gpio_port_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .pad_i(pad_i), .pad_o(pad_o),
    .pad_oe_o(pad_oe), .pull_up_o(pu), .pull_down_o(pd),
    .alt_second_i(alt2), .alt_third_i(alt3), .alt_fourth_i(alt4),
    .pin_level_o(lvl), .pulse_ch45_event_input_o(ev45),
    .pulse_ch67_event_input_o(ev67));
  gpio_board gpio_board_inst (.clk_i(clk_i), .drv_i(pad_o),
    .drv_en_i(pad_oe), .pu_i(pu), .pd_i(pd), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .level_o(pad_i));

  // 50 MHz clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  // ------
  // checks and bus cycles
  // ------
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    chk_reg({24'h00_0000, got}, {24'h00_0000, exp});
  endtask : chk_pin
  // request held until ack is sampled high, then released for a cycle
  task automatic bus(input logic w, input logic [15:0] idx,
                     input logic [1:0] s, input logic [31:0] d);
    int waits;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= {2'b00, s};
    wdat <= d;
    // wait for the answer however long it takes; the watchdog ends a hang
    waits = 0;
    do begin
      @(posedge clk_i);
      waits++;
    end while (ack !== 1'b1);
    rd_q = rdat;
    // taken at the first edge, ack seen high at the second
    chk_reg(32'(waits), 32'h0000_0002);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus
  task automatic rd(input logic [15:0] idx);
    bus(1'b0, idx, 2'b11, 32'h0000_0000);
  endtask : rd
  task automatic settle;
    repeat (4) @(posedge clk_i);
  endtask : settle
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // output enables expected per drive code and data
  function automatic logic [7:0] exp_oe(input int c, input logic [7:0] d);
    return c == 1 ? d : c == 2 ? ~d : c == 3 ? 8'hff : 8'h00;
  endfunction : exp_oe
  function automatic logic [7:0] exp_pad(input int c, input logic [7:0] d);
    return exp_oe(c, d) & (c == 1 ? 8'hff : c == 2 ? 8'h00 : d);
  endfunction : exp_pad

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    test_done();
  end

  // ------
  // tests
  // ------
  initial begin
    void'($urandom(32'hdb3b_ede4));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // six registers, then one unmapped index
    for (int i = 0; i < 7; i++) begin
      rd(`PIN_LEVEL_DATA_IDX + 16'(i));
      chk_reg(rd_q, `BUS_WORD_RST);
    end
    chk_pin(pad_oe | pu | pd, 8'h00);
    end_test("reset");
    for (int c = 0; c < 4; c++) begin
      dv = (c == 0) ? 8'h00 : 8'($urandom);
      bus(1'b1, `PIN_LEVEL_DATA_IDX, 2'b01, {24'h00_0000, dv});
      bus(1'b1, `DRIVE_CONFIG_LOW_IDX, 2'b11, 32'(c[0] ? 8'hff : 8'h00)
          | 32'(c[1] ? 16'hff00 : 16'h0000));
      settle();
      chk_pin(pad_oe, exp_oe(c, dv));
      chk_pin(pad_o & pad_oe, exp_pad(c, dv));
      rd(`PIN_LEVEL_DATA_IDX);
      chk_reg(rd_q, {24'h00_0000, dv});
      rd(`DRIVE_CONFIG_HIGH_IDX);
      chk_reg(rd_q, c[1] ? 32'h0000_00ff : 32'h0000_0000);
    end
    end_test("output");
    for (int c = 0; c < 4; c++) begin
      mask = (c == 0) ? 8'hff : 8'($urandom);
      dv = 8'($urandom);
      ext_en <= mask;
      ext_val <= 8'($urandom);
      bus(1'b1, `PIN_DIRECTION_IDX, 2'b01, {24'h00_0000, mask});
      bus(1'b1, `PIN_LEVEL_DATA_IDX, 2'b01, {24'h00_0000, dv});
      bus(1'b1, `DRIVE_CONFIG_LOW_IDX, 2'b11, 32'(c[0] ? 8'hff : 8'h00)
          | 32'(c[1] ? 16'hff00 : 16'h0000));
      settle();
      chk_pin(pu, c == 2 ? mask : 8'h00);
      chk_pin(pd, c == 1 ? mask : 8'h00);
      chk_pin(pad_oe & mask, 8'h00);
      chk_pin(lvl & mask, ext_val & mask);
      chk_pin({6'h00, ev67, ev45} & {6'h00, mask[3:2]},
              {6'h00, ext_val[3:2] & mask[3:2]});
      rd(`PIN_LEVEL_DATA_IDX);
      chk_reg(rd_q, {24'h00_0000, (ext_val & mask) | (dv & ~mask)});
    end
    // a write without the low byte lane enabled is ignored
    bus(1'b1, `PIN_DIRECTION_IDX, 2'b00, ~{24'h00_0000, mask});
    rd(`PIN_DIRECTION_IDX);
    chk_reg(rd_q, {24'h00_0000, mask});
    end_test("input");
    ext_en <= 8'h00;
    bus(1'b1, `PIN_DIRECTION_IDX, 2'b01, 32'h0000_0000);
    bus(1'b1, `DRIVE_CONFIG_LOW_IDX, 2'b11, 32'h0000_ffff);
    for (int f = 1; f < 4; f++) begin
      alt2 <= 8'($urandom);
      alt3 <= 8'($urandom);
      alt4 <= 8'($urandom);
      bus(1'b1, `FUNCTION_SELECT_LOW_IDX, 2'b11, 32'(f[0] ? 8'hff : 8'h00)
          | 32'(f[1] ? 16'hff00 : 16'h0000));
      settle();
      chk_pin(pad_o, f == 1 ? alt2 & `SECOND_FUNC_PINS : f == 2 ?
              alt3 & `THIRD_FUNC_PINS : alt4 & `FOURTH_FUNC_PINS);
    end
    bus(1'b1, `FUNCTION_SELECT_HIGH_IDX, 2'b01, 32'h0000_005a);
    rd(`FUNCTION_SELECT_LOW_IDX);
    chk_reg(rd_q, 32'h0000_5aff);
    end_test("function");
    test_done();
  end
endmodule : gpio_port_test
`default_nettype wire
